// ### design/sar_status_regs.sv
// Sync status, alarm flags and sensor power control behind the configuration port
//
// Contract
// - Sleep bit powers down temperature sensor
// - Divider realign sets bit 3, W1C
// - Divider match bit 2 read-only, last pulse
// - Divider match ignores frame clock alignment
// - Oscillator sync event sets bit 1, W1C
// - SYSREF detect sets bit 0, W1C rearms
// - Link falling while enabled sets bit 7
// - Link down past limit sets bit 6
// - Lane CRC error sets bit 5
// - CRC alarm only in 64b/66b mode
// - Any reset sets chip reset bit 1
// - SYSREF misalignment sets bit 0, W1C
// - Alarm bits 4 to 2 read zero
// - Temperature valid only while sensor awake
`timescale 1ns/1ps
module sar_status_regs
  import sar_pkg::*;
#(
  parameter int LIMIT_W = sar_pkg::SAR_LIMIT_W
) (
  input  wire logic                 core_clk_in,     // 100 MHz core clock
  input  wire logic                 resetn_in,       // Async reset, active low
  input  wire logic                 cfg_wr_in,       // Write strobe, one cycle
  input  wire logic                 cfg_rd_in,       // Read strobe, one cycle
  input  wire logic [11:0]          cfg_addr_in,     // Register address
  input  wire logic [7:0]           cfg_wdata_in,    // Write data
  input  wire logic                 soft_reset_in,   // Software reset trigger pulse
  input  wire sar_pkg::sar_clk_ev_s clk_ev_in,       // Clocking events
  input  wire sar_pkg::sar_link_ev_s link_ev_in,     // Link receiver events
  input  wire logic [LIMIT_W-1:0]   link_down_limit_in, // Link-down limit in cycles
  input  wire logic [7:0]           temperature_reading_in, // Raw sensor code
  output logic [7:0]                cfg_rdata_out,   // Read data
  output logic                      cfg_rvalid_out,  // Read data valid pulse
  output logic                      temp_sensor_power_down_out // Sensor sleep
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (LIMIT_W < 1 || LIMIT_W > 32) begin : g_bad_w
    $error("LIMIT_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic wr_power;  // Write to sensor power register
  logic wr_sync;   // Write to sync flags
  logic wr_alarm;  // Write to alarm flags
  assign wr_power = cfg_wr_in && (cfg_addr_in == SAR_OFS_TEMP_POWER);
  assign wr_sync  = cfg_wr_in && (cfg_addr_in == SAR_OFS_SYNC_FLAGS);
  assign wr_alarm = cfg_wr_in && (cfg_addr_in == SAR_OFS_SYS_ALARM);

  ////////////////////////////////////////////////////////////////////////////
  // Sensor power control register; all eight bits are plain storage
  logic [7:0] power_q;
  logic [7:0] power_d;

  // Next value of the power register
  always_comb begin
    power_d = power_q;
    if (wr_power) begin
      power_d = cfg_wdata_in;
    end
  end

  // Power register, which is also the flop that drives the sleep output
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      power_q <= SAR_RST_TEMP_POWER;
    end else begin
      power_q <= power_d;
    end
  end

  // Sleep output follows the stored bit straight from the flop
  assign temp_sensor_power_down_out = power_q[SAR_BIT_TS_POWER_DOWN];

  ////////////////////////////////////////////////////////////////////////////
  // Event edge and link-down tracking
  logic             link_up_q;    // Last link-up level
  logic             link_up_d;
  logic [LIMIT_W:0] down_cnt_q;   // Cycles spent down while enabled
  logic [LIMIT_W:0] down_cnt_d;
  logic             timeout_q;    // Limit exceeded once this outage
  logic             timeout_d;
  logic             div_match_q;  // Last SYSREF pulse consistent
  logic             div_match_d;
  logic             rst_pend_q;   // Reset alarm still to be raised
  logic             rst_pend_d;
  logic             link_fall;
  logic             timeout_hit;

  // Falling edge of link-up qualified by the enable
  assign link_fall = link_ev_in.link_enable && link_up_q && !link_ev_in.link_up;

  // Next values of the tracking state
  always_comb begin
    link_up_d   = link_ev_in.link_up;
    down_cnt_d  = down_cnt_q;
    timeout_d   = timeout_q;
    div_match_d = div_match_q;
    rst_pend_d  = 1'b0;
    timeout_hit = 1'b0;
    // Count only an outage with the link enabled; saturate at the top
    if (!link_ev_in.link_enable || link_ev_in.link_up) begin
      down_cnt_d = '0;
      timeout_d  = 1'b0;
    end else begin
      if (down_cnt_q != {(LIMIT_W+1){1'b1}}) begin
        down_cnt_d = down_cnt_q + 1'b1;
      end
      // Strictly longer than the limit, raised once per outage
      if (!timeout_q && (down_cnt_q > {1'b0, link_down_limit_in})) begin
        timeout_hit = 1'b1;
        timeout_d   = 1'b1;
      end
    end
    // Only the divider phase is compared, the frame clock is not consulted
    if (clk_ev_in.div_match_vld) begin
      div_match_d = clk_ev_in.div_match;
    end
  end

  // Tracking registers; reset pending goes high in reset, drops after
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link_up_q   <= 1'b0;
      down_cnt_q  <= '0;
      timeout_q   <= 1'b0;
      div_match_q <= 1'b0;
      rst_pend_q  <= 1'b1;
    end else begin
      link_up_q   <= link_up_d;
      down_cnt_q  <= down_cnt_d;
      timeout_q   <= timeout_d;
      div_match_q <= div_match_d;
      rst_pend_q  <= rst_pend_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags: sync register bits 0,1,3 and alarm bits 0,1,5,6,7
  logic [7:0] sync_set;
  logic [7:0] sync_flag;
  logic [7:0] alm_set;
  logic [7:0] alm_flag;

  // Set sources for each sticky flag
  always_comb begin
    sync_set = 8'h00;
    alm_set  = 8'h00;
    sync_set[SAR_BIT_SYSREF_SEEN]   = clk_ev_in.sysref_seen_flag;
    sync_set[SAR_BIT_OSC_SYNC_SEEN] = clk_ev_in.osc_sync;
    sync_set[SAR_BIT_DIV_REALIGN]   = clk_ev_in.div_realigned;
    alm_set[SAR_BIT_LINK_LOSS]      = link_fall;
    alm_set[SAR_BIT_LINK_TIMEOUT]   = timeout_hit;
    // CRC errors count only in 64b/66b with the link enabled
    alm_set[SAR_BIT_CRC_FAULT] = link_ev_in.crc_fault && link_ev_in.enc_64b66b
                                 && link_ev_in.link_enable;
    // Soft reset and any hard reset both raise the chip-reset alarm
    alm_set[SAR_BIT_CHIP_RESET] = soft_reset_in || rst_pend_q;
    alm_set[SAR_BIT_SYSREF_MISALIGN] = clk_ev_in.div_misalign
      || (link_ev_in.sysref_misalign && link_ev_in.link_enable);
  end

  // Reset values come from package constants, as a parameter must be fixed

  // One sticky cell per implemented bit; reserved bits are never built
  for (genvar i = 0; i < 8; i++) begin : g_bits
    if (SAR_SYNC_W1C_MASK[i]) begin : g_sync
      sar_sticky_bit #(.RESET_VAL(SAR_RST_SYNC_FLAGS[i])) u_sync (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .set_in      (sync_set[i]),
        .clr_in      (wr_sync && cfg_wdata_in[i]),
        .flag_out    (sync_flag[i])
      );
    end else begin : g_sync_none
      assign sync_flag[i] = 1'b0;
    end
    if (SAR_SYS_ALARM_WMASK[i]) begin : g_alm
      sar_sticky_bit #(.RESET_VAL(SAR_RST_SYS_ALARM[i])) u_alm (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .set_in      (alm_set[i]),
        .clr_in      (wr_alarm && cfg_wdata_in[i]),
        .flag_out    (alm_flag[i])
      );
    end else begin : g_alm_none
      assign alm_flag[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, registered one cycle after the read strobe
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;

  // Read multiplexer; unmapped addresses return zero
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = cfg_rd_in;
    if (cfg_rd_in) begin
      case (cfg_addr_in)
        SAR_OFS_TEMP_READ: begin
          // Sleeping sensor gives no valid code, so zero is returned
          rdata_d = power_q[SAR_BIT_TS_POWER_DOWN] ? 8'h00 : temperature_reading_in;
        end
        SAR_OFS_TEMP_POWER: begin
          rdata_d = power_q;
        end
        SAR_OFS_SYNC_FLAGS: begin
          rdata_d = sync_flag;
          rdata_d[SAR_BIT_DIV_MATCH] = div_match_q;
        end
        SAR_OFS_SYS_ALARM: begin
          rdata_d = alm_flag & SAR_SYS_ALARM_WMASK;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // Read data registers
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign cfg_rdata_out  = rdata_q;
  assign cfg_rvalid_out = rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_sleep_follows_write: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    wr_power |=> temp_sensor_power_down_out == $past(cfg_wdata_in[0]))
    else $error("sleep bit not taken from write");

  chk_realign_sets: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    clk_ev_in.div_realigned |=> sync_flag[SAR_BIT_DIV_REALIGN])
    else $error("realign flag not set");

  chk_match_no_clear: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !clk_ev_in.div_match_vld |=> div_match_q == $past(div_match_q))
    else $error("divider match changed without pulse");

  chk_match_tracks: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    clk_ev_in.div_match_vld |=> div_match_q == $past(clk_ev_in.div_match))
    else $error("divider match not captured");

  chk_osc_sets: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    clk_ev_in.osc_sync |=> sync_flag[SAR_BIT_OSC_SYNC_SEEN])
    else $error("oscillator sync flag not set");

  chk_sysref_clear: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (wr_sync && cfg_wdata_in[0] && !clk_ev_in.sysref_seen_flag) |=> !sync_flag[0])
    else $error("sysref flag not cleared");

  chk_link_loss: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (link_ev_in.link_enable && $fell(link_ev_in.link_up)) |=> alm_flag[SAR_BIT_LINK_LOSS])
    else $error("link loss not flagged");

  chk_timeout_late: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (link_ev_in.link_enable && !link_ev_in.link_up && !alm_flag[SAR_BIT_LINK_TIMEOUT]
     && down_cnt_q <= {1'b0, link_down_limit_in}) |=> !alm_flag[SAR_BIT_LINK_TIMEOUT])
    else $error("timeout raised too early");

  chk_crc_mode: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (!alm_flag[SAR_BIT_CRC_FAULT] && !link_ev_in.enc_64b66b) |=> !alm_flag[SAR_BIT_CRC_FAULT])
    else $error("crc alarm outside 64b/66b");

  chk_crc_sets: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (link_ev_in.crc_fault && link_ev_in.enc_64b66b && link_ev_in.link_enable) |=> alm_flag[5])
    else $error("crc alarm not set");

  chk_reset_alarm: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    soft_reset_in |=> alm_flag[SAR_BIT_CHIP_RESET])
    else $error("chip reset alarm not set");

  chk_misalign: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    clk_ev_in.div_misalign |=> alm_flag[SAR_BIT_SYSREF_MISALIGN])
    else $error("misalign alarm not set");

  chk_reserved_zero: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    $past(cfg_rd_in && cfg_addr_in == SAR_OFS_SYS_ALARM) |-> cfg_rdata_out[4:2] == 3'b000)
    else $error("reserved alarm bits not zero");

  chk_temp_sleep: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (cfg_rd_in && cfg_addr_in == SAR_OFS_TEMP_READ && power_q[0]) |=> cfg_rdata_out == 8'h00)
    else $error("temperature read while asleep");

endmodule

// ### design/sar_pkg.sv
// Package of offsets, field positions, reset values and carriers for the sync/alarm register bank
package sar_pkg;

  // Register addresses on the configuration port
  localparam logic [11:0] SAR_OFS_TEMP_READ  = 12'h400;
  localparam logic [11:0] SAR_OFS_TEMP_POWER = 12'h401;
  localparam logic [11:0] SAR_OFS_SYNC_FLAGS = 12'h410;
  localparam logic [11:0] SAR_OFS_SYS_ALARM  = 12'h430;

  // Field positions in the sensor power control register
  localparam int SAR_BIT_TS_POWER_DOWN = 0;

  // Field positions in the sync event flags register
  localparam int SAR_BIT_SYSREF_SEEN   = 0;
  localparam int SAR_BIT_OSC_SYNC_SEEN = 1;
  localparam int SAR_BIT_DIV_MATCH     = 2;
  localparam int SAR_BIT_DIV_REALIGN   = 3;

  // Field positions in the system alarm register
  localparam int SAR_BIT_SYSREF_MISALIGN = 0;
  localparam int SAR_BIT_CHIP_RESET      = 1;
  localparam int SAR_BIT_CRC_FAULT       = 5;
  localparam int SAR_BIT_LINK_TIMEOUT    = 6;
  localparam int SAR_BIT_LINK_LOSS       = 7;

  // Reset values and implemented-bit masks
  localparam logic [7:0] SAR_RST_TEMP_POWER = 8'h00;
  localparam logic [7:0] SAR_RST_SYNC_FLAGS = 8'h00;
  localparam logic [7:0] SAR_RST_SYS_ALARM  = 8'h02;
  localparam logic [7:0] SAR_SYS_ALARM_WMASK = 8'he3;
  localparam logic [7:0] SAR_SYNC_W1C_MASK   = 8'h0b;

  // Default link-down limit width in bits
  localparam int SAR_LIMIT_W = 16;

  // Link receiver event carrier
  typedef struct packed {
    logic link_enable;
    logic link_up;
    logic enc_64b66b;
    logic crc_fault;
    logic sysref_misalign;
  } sar_link_ev_s;

  // Clocking event carrier
  typedef struct packed {
    logic sysref_seen_flag;
    logic div_realigned;
    logic div_match;
    logic div_match_vld;
    logic osc_sync;
    logic div_misalign;
  } sar_clk_ev_s;

endpackage

// ### design/sar_sticky_bit.sv
// One sticky write-one-to-clear status bit where a set beats a clear
`timescale 1ns/1ps
module sar_sticky_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic core_clk_in,
  input  wire logic resetn_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);

  logic flag_q;
  logic flag_d;

  // Next value: set wins over a same-cycle clear
  always_comb begin
    flag_d = flag_q;
    if (clr_in) begin
      flag_d = 1'b0;
    end
    if (set_in) begin
      flag_d = 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flag_q <= RESET_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;

  ////////////////////////////////////////////////////////////////////////////
  chk_set_beats_clr: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    set_in |=> flag_q) else $error("sticky bit lost a set");

endmodule

// ### tb/sar_status_regs_tb_top.sv
// Self-checking bench for the sync status and alarm register bank
`timescale 1ns/1ps
module sar_status_regs_tb_top;
  import sar_pkg::*;

  localparam int LIM = 8;                 // Short link-down limit keeps the run brief

  logic              clk;                 // Core clock
  logic              rstn;                // Async reset, active low
  logic              wr;                  // Write strobe
  logic              rd;                  // Read strobe
  logic [11:0]       addr;                // Register address
  logic [7:0]        wdata;               // Write data
  logic              soft_rst;            // Software reset trigger
  sar_clk_ev_s       cev;                 // Clocking events
  sar_link_ev_s      lev;                 // Link events
  logic [15:0]       lim;                 // Link-down limit
  logic [7:0]        temp;                // Sensor code
  logic [7:0]        rdata;               // Read data
  logic              rvalid;              // Read valid
  logic              pdown;               // Sensor sleep
  logic [7:0]        v;                   // Last read value
  int                num_errors;          // Mismatch count
  int                comparisons;         // Compare count

  sar_status_regs #(.LIMIT_W(16)) dut (
    .core_clk_in               (clk),
    .resetn_in                 (rstn),
    .cfg_wr_in                 (wr),
    .cfg_rd_in                 (rd),
    .cfg_addr_in               (addr),
    .cfg_wdata_in              (wdata),
    .soft_reset_in             (soft_rst),
    .clk_ev_in                 (cev),
    .link_ev_in                (lev),
    .link_down_limit_in        (lim),
    .temperature_reading_in    (temp),
    .cfg_rdata_out             (rdata),
    .cfg_rvalid_out            (rvalid),
    .temp_sensor_power_down_out(pdown)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog sized well beyond the under two hundred cycles the tests need
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and bus tasks
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask

  // Waits a number of falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One read; data is looked at in the single cycle that valid stands
  task automatic rdr(input logic [11:0] a);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk1("rvalid", 1'b1, rvalid);
    v = rdata;
  endtask

  task automatic wrr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Reads a register and compares the whole byte
  task automatic expect_reg(input string n, input logic [11:0] a, input logic [7:0] e);
    rdr(a);
    chk8(n, e, v);
  endtask

  // One-cycle clocking event
  task automatic pulse_clk(input sar_clk_ev_s e);
    @(negedge clk);
    cev = e;
    @(negedge clk);
    cev = '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_alarm();
    expect_reg("power ctrl reset", SAR_OFS_TEMP_POWER, 8'h00);
    // Valid must stand for exactly one cycle
    cyc(1);
    chk1("rvalid drop", 1'b0, rvalid);
    expect_reg("sync reset", SAR_OFS_SYNC_FLAGS, 8'h00);
    expect_reg("alarm after reset", SAR_OFS_SYS_ALARM, 8'h02);
    wrr(SAR_OFS_SYS_ALARM, 8'h02);
    expect_reg("alarm cleared", SAR_OFS_SYS_ALARM, 8'h00);
    @(negedge clk);
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    expect_reg("alarm soft reset", SAR_OFS_SYS_ALARM, 8'h02);
    wrr(SAR_OFS_SYS_ALARM, 8'hff);
    expect_reg("unmapped", 12'h123, 8'h00);
  endtask

  task automatic t_sensor();
    wrr(SAR_OFS_TEMP_POWER, 8'ha5);
    expect_reg("power ctrl rw", SAR_OFS_TEMP_POWER, 8'ha5);
    chk1("sensor sleep", 1'b1, pdown);
    expect_reg("temp asleep", SAR_OFS_TEMP_READ, 8'h00);
    wrr(SAR_OFS_TEMP_POWER, 8'h00);
    chk1("sensor awake", 1'b0, pdown);
    expect_reg("temp awake", SAR_OFS_TEMP_READ, 8'h6e);
  endtask

  // Each sticky sync flag: set, clear, set again
  task automatic t_sync_sticky();
    sar_clk_ev_s e;
    logic [7:0]  m;
    for (int i = 0; i < 3; i++) begin
      e = '0;
      case (i)
        0: begin
          e.sysref_seen_flag = 1'b1;
          m = 8'h01;
        end
        1: begin
          e.osc_sync = 1'b1;
          m = 8'h02;
        end
        default: begin
          e.div_realigned = 1'b1;
          m = 8'h08;
        end
      endcase
      pulse_clk(e);
      expect_reg("sync set", SAR_OFS_SYNC_FLAGS, m);
      wrr(SAR_OFS_SYNC_FLAGS, m);
      expect_reg("sync clear", SAR_OFS_SYNC_FLAGS, 8'h00);
      pulse_clk(e);
      expect_reg("sync rearm", SAR_OFS_SYNC_FLAGS, m);
      wrr(SAR_OFS_SYNC_FLAGS, m);
    end
  endtask

  task automatic t_div_match();
    sar_clk_ev_s e;
    e = '0;
    e.div_match = 1'b1;
    e.div_match_vld = 1'b1;
    lev.link_enable = 1'b1;
    pulse_clk(e);
    wrr(SAR_OFS_SYNC_FLAGS, 8'hff);
    expect_reg("match not clearable", SAR_OFS_SYNC_FLAGS, 8'h04);
    e.div_match = 1'b0;
    lev.link_enable = 1'b0;
    pulse_clk(e);
    expect_reg("match follows pulse", SAR_OFS_SYNC_FLAGS, 8'h00);
  endtask

  // Set event and clear write land on the same edge
  task automatic t_set_beats_clear();
    @(negedge clk);
    wr = 1'b1;
    addr = SAR_OFS_SYNC_FLAGS;
    wdata = 8'h01;
    cev.sysref_seen_flag = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    cev = '0;
    expect_reg("set beats clear", SAR_OFS_SYNC_FLAGS, 8'h01);
    wrr(SAR_OFS_SYNC_FLAGS, 8'h01);
  endtask

  task automatic t_link();
    @(negedge clk);
    lev.link_up = 1'b1;
    cyc(2);
    lev.link_up = 1'b0;
    expect_reg("drop while disabled", SAR_OFS_SYS_ALARM, 8'h00);
    lev.link_up = 1'b1;
    lev.link_enable = 1'b1;
    cyc(2);
    lev.link_up = 1'b0;
    expect_reg("loss not yet timeout", SAR_OFS_SYS_ALARM, 8'h80);
    // This read samples the edge where the count first exceeds the limit
    cyc(LIM - 2);
    expect_reg("no timeout at limit", SAR_OFS_SYS_ALARM, 8'h80);
    expect_reg("timeout", SAR_OFS_SYS_ALARM, 8'hc0);
    lev.link_up = 1'b1;
    wrr(SAR_OFS_SYS_ALARM, 8'hc0);
    expect_reg("link clear", SAR_OFS_SYS_ALARM, 8'h00);
  endtask

  task automatic t_crc_misalign();
    sar_clk_ev_s e;
    @(negedge clk);
    lev.crc_fault = 1'b1;
    @(negedge clk);
    lev.crc_fault = 1'b0;
    expect_reg("crc other mode", SAR_OFS_SYS_ALARM, 8'h00);
    lev.enc_64b66b = 1'b1;
    lev.crc_fault = 1'b1;
    @(negedge clk);
    lev.crc_fault = 1'b0;
    expect_reg("crc 64b66b", SAR_OFS_SYS_ALARM, 8'h20);
    wrr(SAR_OFS_SYS_ALARM, 8'hff);
    expect_reg("crc cleared", SAR_OFS_SYS_ALARM, 8'h00);
    @(negedge clk);
    lev.sysref_misalign = 1'b1;
    @(negedge clk);
    lev.sysref_misalign = 1'b0;
    expect_reg("link misalign", SAR_OFS_SYS_ALARM, 8'h01);
    wrr(SAR_OFS_SYS_ALARM, 8'h01);
    e = '0;
    e.div_misalign = 1'b1;
    pulse_clk(e);
    expect_reg("divider misalign", SAR_OFS_SYS_ALARM, 8'h01);
    wrr(SAR_OFS_SYS_ALARM, 8'h1c);
    expect_reg("reserved no effect", SAR_OFS_SYS_ALARM, 8'h01);
    wrr(SAR_OFS_SYS_ALARM, 8'h01);
    expect_reg("misalign cleared", SAR_OFS_SYS_ALARM, 8'h00);
    // Link-side misalignment counts only with the link enabled
    lev.link_enable = 1'b0;
    lev.sysref_misalign = 1'b1;
    @(negedge clk);
    lev.sysref_misalign = 1'b0;
    expect_reg("misalign link off", SAR_OFS_SYS_ALARM, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    num_errors = 0;
    comparisons = 0;
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h000;
    wdata = 8'h00;
    soft_rst = 1'b0;
    cev = '0;
    lev = '0;
    lim = 16'(LIM);
    temp = 8'h6e;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    cyc(2);
    t_reset_alarm();
    t_sensor();
    t_sync_sticky();
    t_div_match();
    t_set_beats_clear();
    t_link();
    t_crc_misalign();
    end_sim();
  end
endmodule
